// ==== verilog/spc_pkg.sv ====
// Constants and types of the strap pin configuration decoder
// Summary of operation
// - Channel-enable pin 0 gives high-speed standby, 1 turns channels on
// - Source-select code 00/01/10/11 routes high-speed source A/B/C/D out
// - Same code routes auxiliary group A/B/C/D to the common aux lines
// - In pin mode, input termination is held on
// - In pin mode, pulse-on-switch termination stays off for all sources
// - In pin mode, one pin sets equalization of every input channel
// - Equalization pin 0 selects 6 dB, 1 selects 12 dB
// - Pre-emphasis code 00/01/10/11 gives 0/2/4/6 dB on all outputs
// - Output-termination pin 0 turns termination off, 1 turns it on
// - Output-current pin 0 selects 10 mA, 1 selects 20 mA
// - Register path sets input and output termination independently
// - Pins govern from reset until first register access, then registers
package spc_pkg;
	localparam int unsigned SPC_ADDR_W = 6;
	localparam int unsigned SPC_NWREG = 8;
	localparam int unsigned SPC_NREG = 10;
	localparam int unsigned SPC_SYNC_STAGES = 2;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] SPC_OFS_HS_MODES = 6'h00;
	localparam logic [5:0] SPC_OFS_AUX_MODES = 6'h04;
	localparam logic [5:0] SPC_OFS_RX = 6'h08;
	localparam logic [5:0] SPC_OFS_PULSE1 = 6'h0C;
	localparam logic [5:0] SPC_OFS_PULSE2 = 6'h10;
	localparam logic [5:0] SPC_OFS_EQ1 = 6'h14;
	localparam logic [5:0] SPC_OFS_EQ2 = 6'h18;
	localparam logic [5:0] SPC_OFS_TX = 6'h1C;
	localparam logic [5:0] SPC_OFS_STATUS = 6'h20;
	localparam logic [5:0] SPC_OFS_STRAP = 6'h24;
	localparam logic [5:0] SPC_OFS [SPC_NREG] = '{SPC_OFS_HS_MODES,
		SPC_OFS_AUX_MODES, SPC_OFS_RX, SPC_OFS_PULSE1, SPC_OFS_PULSE2,
		SPC_OFS_EQ1, SPC_OFS_EQ2, SPC_OFS_TX, SPC_OFS_STATUS,
		SPC_OFS_STRAP};
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam int unsigned SPC_IDX_HS = 0;
	localparam int unsigned SPC_IDX_AUX = 1;
	localparam int unsigned SPC_IDX_RX = 2;
	localparam int unsigned SPC_IDX_PULSE1 = 3;
	localparam int unsigned SPC_IDX_PULSE2 = 4;
	localparam int unsigned SPC_IDX_EQ1 = 5;
	localparam int unsigned SPC_IDX_EQ2 = 6;
	localparam int unsigned SPC_IDX_TX = 7;
	localparam int unsigned SPC_IDX_STATUS = 8;
	localparam int unsigned SPC_IDX_STRAP = 9;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned SPC_EN_BIT = 6;
	localparam int unsigned SPC_SRC_LSB = 0;
	localparam int unsigned SPC_RX_TERM_BIT = 0;
	localparam int unsigned SPC_SERIAL_OUTPUT_CURRENT_FIELD_BIT = 0;
	localparam int unsigned SPC_TX_OTO_BIT = 1;
	localparam int unsigned SPC_TX_PE_LSB = 2;
	localparam int unsigned SPC_STAT_SERIAL_BIT = 0;
	localparam int unsigned SPC_STRAP_EN_BIT = 0;
	localparam int unsigned SPC_STRAP_SRC_LSB = 1;
	localparam int unsigned SPC_STRAP_EQ_BIT = 3;
	localparam int unsigned SPC_STRAP_PE_LSB = 4;
	localparam int unsigned SPC_STRAP_OTO_BIT = 6;
	localparam int unsigned SPC_STRAP_OCL_BIT = 7;
	// ----------------------------------------------------------------
	// Writable bits and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SPC_WMASK [SPC_NWREG] = '{8'h43, 8'h43, 8'h01,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
	localparam logic [7:0] SPC_RST [SPC_NWREG] = '{8'h00, 8'h40, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic SPC_IN_TERM_FIXED = 1'b1;
	localparam logic SPC_AUX_EN_FIXED = 1'b1;
	localparam logic [7:0] SPC_PULSE_FIXED = 8'h00;
	localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SPC_RESP_DECERR = 2'h3;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum {SPC_WR_COLLECT, SPC_WR_RESP} spc_wr_state_t;
	typedef enum {SPC_RD_IDLE, SPC_RD_DATA} spc_rd_state_t;
endpackage

// ==== verilog/spc_strap_if.sv ====
// Carrier of the strap-derived register image between decoder modules
interface spc_strap_if
	import spc_pkg::*;
;
	logic [7:0] image [SPC_NWREG];
	logic [7:0] strap;
	modport drive (output image, output strap);
	modport sink (input image, input strap);
endinterface

// ==== verilog/spc_pin_sync.sv ====
// Strap pin synchroniser and pin-to-register-image decoder
module spc_pin_sync
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Strap pins
	input wire logic hs_channel_enable_pin,
	input wire logic [1:0] source_select_pins,
	input wire logic equalization_level_pin,
	input wire logic [1:0] preemphasis_level_pins,
	input wire logic output_termination_pin,
	input wire logic output_current_pin,
	// Register image
	spc_strap_if.drive cfg
);
	// ----------------------------------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------------------------------
	logic [7:0] raw;
	logic [7:0] sync_a;
	logic [7:0] sync_b;
	logic [7:0] eq_all;

	assign raw = {output_current_pin, output_termination_pin,
		preemphasis_level_pins, equalization_level_pin,
		source_select_pins, hs_channel_enable_pin};

	always_ff @(posedge clock) begin
		if (!nrst) begin
			sync_a <= 8'h00;
			sync_b <= 8'h00;
		end else begin
			sync_a <= raw;
			sync_b <= sync_a;
		end
	end

	// ----------------------------------------------------------------
	// Image decode
	// ----------------------------------------------------------------
	assign eq_all = {8{sync_b[SPC_STRAP_EQ_BIT]}};
	assign cfg.strap = sync_b;
	assign cfg.image[SPC_IDX_HS] = {1'b0, sync_b[SPC_STRAP_EN_BIT], 4'h0,
		sync_b[SPC_STRAP_SRC_LSB +: 2]};
	assign cfg.image[SPC_IDX_AUX] = {1'b0, SPC_AUX_EN_FIXED, 4'h0,
		sync_b[SPC_STRAP_SRC_LSB +: 2]};
	assign cfg.image[SPC_IDX_RX] = {7'h00, SPC_IN_TERM_FIXED};
	assign cfg.image[SPC_IDX_PULSE1] = SPC_PULSE_FIXED;
	assign cfg.image[SPC_IDX_PULSE2] = SPC_PULSE_FIXED;
	assign cfg.image[SPC_IDX_EQ1] = eq_all;
	assign cfg.image[SPC_IDX_EQ2] = eq_all;
	assign cfg.image[SPC_IDX_TX] = {4'h0, sync_b[SPC_STRAP_PE_LSB +: 2],
		sync_b[SPC_STRAP_OTO_BIT],
		sync_b[SPC_STRAP_OCL_BIT]};
endmodule

// ==== verilog/spc_pin_config_decode.sv ====
// Strap pin configuration decoder with AXI4-Lite register takeover
//
// Added by the designer: the address map and the AXI4-Lite slave port.
module spc_pin_config_decode
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,

	// AXI4-Lite write address channel
	input wire logic [SPC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,

	// AXI4-Lite write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,

	// AXI4-Lite write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,

	// AXI4-Lite read address channel
	input wire logic [SPC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,

	// AXI4-Lite read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,

	// Strap pins
	input wire logic hs_channel_enable_pin,
	input wire logic [1:0] source_select_pins,
	input wire logic equalization_level_pin,
	input wire logic [1:0] preemphasis_level_pins,
	input wire logic output_termination_pin,
	input wire logic output_current_pin,

	// High-speed crosspoint
	output logic hs_enable,
	output logic [1:0] hs_source_sel,
	output logic [3:0] hs_source_onehot,

	// Auxiliary crosspoint
	output logic aux_enable,
	output logic [1:0] aux_source_sel,
	output logic [3:0] aux_source_onehot,

	// Receiver settings
	output logic in_term_enable,
	output logic [15:0] pulse_term_sel,
	output logic [15:0] eq_level_high,

	// Transmitter settings
	output logic [1:0] preemphasis_level,
	output logic out_term_enable,
	output logic out_current_high,

	// Mode
	output logic serial_mode
);
	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [SPC_NREG-1:0] spc_sel(
		input logic [SPC_ADDR_W-1:0] a
	);
		logic [SPC_NREG-1:0] s;
		s = '0;
		for (int i = 0; i < SPC_NREG; i++) begin
			if (a == SPC_OFS[i]) begin
				s[i] = 1'b1;
			end
		end
		return s;
	endfunction

	// ----------------------------------------------------------------
	// Strap synchroniser
	// ----------------------------------------------------------------
	spc_strap_if pins_cfg();

	spc_pin_sync u_sync (
		.clock(clock),
		.nrst(nrst),
		.hs_channel_enable_pin(hs_channel_enable_pin),
		.source_select_pins(source_select_pins),
		.equalization_level_pin(equalization_level_pin),
		.preemphasis_level_pins(preemphasis_level_pins),
		.output_termination_pin(output_termination_pin),
		.output_current_pin(output_current_pin),
		.cfg(pins_cfg.drive)
	);

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	spc_wr_state_t wr_state;
	spc_wr_state_t next_wr_state;
	logic aw_held;
	logic w_held;
	logic [SPC_ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	wire aw_take;
	wire w_take;
	wire wr_fire;
	wire [SPC_NREG-1:0] wr_sel;
	wire wr_hit;

	assign s_axi_awready = (wr_state == SPC_WR_COLLECT) && !aw_held;
	assign s_axi_wready = (wr_state == SPC_WR_COLLECT) && !w_held;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign wr_fire = (wr_state == SPC_WR_COLLECT) && aw_held && w_held;
	assign wr_sel = spc_sel(aw_addr);
	assign wr_hit = |wr_sel;
	assign s_axi_bvalid = (wr_state == SPC_WR_RESP);
	assign s_axi_bresp = bresp;

	always_comb begin
		next_wr_state = wr_state;
		next_bresp = bresp;
		unique case (wr_state)
			SPC_WR_COLLECT: begin
				if (wr_fire) begin
					next_wr_state = SPC_WR_RESP;
					next_bresp = wr_hit ? SPC_RESP_OKAY : SPC_RESP_DECERR;
				end
			end
			SPC_WR_RESP: begin
				if (s_axi_bready) begin
					next_wr_state = SPC_WR_COLLECT;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			wr_state <= SPC_WR_COLLECT;
			bresp <= SPC_RESP_OKAY;
		end else begin
			wr_state <= next_wr_state;
			bresp <= next_bresp;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			aw_held <= (aw_held || aw_take) && !wr_fire;
			w_held <= (w_held || w_take) && !wr_fire;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			aw_addr <= '0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	spc_rd_state_t rd_state;
	spc_rd_state_t next_rd_state;
	logic [7:0] rd_byte;
	logic [1:0] rresp;
	wire ar_take;
	wire [SPC_NREG-1:0] rd_sel;
	wire rd_hit;
	logic [7:0] rd_mux;

	assign s_axi_arready = (rd_state == SPC_RD_IDLE);
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign rd_sel = spc_sel(s_axi_araddr);
	assign rd_hit = |rd_sel;
	assign s_axi_rvalid = (rd_state == SPC_RD_DATA);
	assign s_axi_rdata = {24'h000000, rd_byte};
	assign s_axi_rresp = rresp;

	always_comb begin
		next_rd_state = rd_state;
		unique case (rd_state)
			SPC_RD_IDLE: begin
				if (ar_take) begin
					next_rd_state = SPC_RD_DATA;
				end
			end
			SPC_RD_DATA: begin
				if (s_axi_rready) begin
					next_rd_state = SPC_RD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			rd_state <= SPC_RD_IDLE;
			rd_byte <= 8'h00;
			rresp <= SPC_RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			if (ar_take) begin
				rd_byte <= rd_mux;
				rresp <= rd_hit ? SPC_RESP_OKAY : SPC_RESP_DECERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode takeover
	// ----------------------------------------------------------------
	wire reg_access;

	assign reg_access = (wr_fire && wr_hit) || (ar_take && rd_hit);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			serial_mode <= 1'b0;
		end else if (reg_access) begin
			serial_mode <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] regs [SPC_NWREG];
	logic [7:0] cur [SPC_NWREG];
	logic [7:0] status_byte;

	assign status_byte = {7'h00, serial_mode};

	generate
		for (genvar i = 0; i < SPC_NWREG; i++) begin : g_reg
			wire wr_this;
			wire [7:0] merged;

			assign wr_this = wr_fire && wr_sel[i] && w_lane0;
			assign merged = w_byte & SPC_WMASK[i];
			// Register path selects source while pins no longer govern
			assign cur[i] = serial_mode ? regs[i] : pins_cfg.image[i];

			always_ff @(posedge clock) begin
				if (!nrst) begin
					regs[i] <= SPC_RST[i];
				end else if (wr_this) begin
					regs[i] <= merged;
				end else if (!serial_mode) begin
					regs[i] <= pins_cfg.image[i];
				end
			end
		end
	endgenerate

	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < SPC_NWREG; i++) begin
			if (rd_sel[i]) begin
				rd_mux = cur[i];
			end
		end
		if (rd_sel[SPC_IDX_STATUS]) begin
			rd_mux = status_byte;
		end
		if (rd_sel[SPC_IDX_STRAP]) begin
			rd_mux = pins_cfg.strap;
		end
	end

	// ----------------------------------------------------------------
	// Settings decode
	// ----------------------------------------------------------------
	wire next_hs_enable;
	wire [1:0] next_hs_source_sel;
	wire next_aux_enable;
	wire [1:0] next_aux_source_sel;
	wire next_in_term_enable;
	wire [15:0] next_pulse_term_sel;
	wire [15:0] next_eq_level_high;
	wire [1:0] next_preemphasis_level;
	wire next_out_term_enable;
	wire next_out_current_high;

	assign next_hs_enable = cur[SPC_IDX_HS][SPC_EN_BIT];
	assign next_hs_source_sel =
		cur[SPC_IDX_HS][SPC_SRC_LSB +: 2];
	assign next_aux_enable = cur[SPC_IDX_AUX][SPC_EN_BIT];
	assign next_aux_source_sel =
		cur[SPC_IDX_AUX][SPC_SRC_LSB +: 2];
	assign next_in_term_enable =
		cur[SPC_IDX_RX][SPC_RX_TERM_BIT];
	assign next_pulse_term_sel =
		{cur[SPC_IDX_PULSE2], cur[SPC_IDX_PULSE1]};
	assign next_eq_level_high =
		{cur[SPC_IDX_EQ2], cur[SPC_IDX_EQ1]};
	assign next_preemphasis_level =
		cur[SPC_IDX_TX][SPC_TX_PE_LSB +: 2];
	assign next_out_term_enable =
		cur[SPC_IDX_TX][SPC_TX_OTO_BIT];
	assign next_out_current_high =
		cur[SPC_IDX_TX][SPC_SERIAL_OUTPUT_CURRENT_FIELD_BIT];

	always_ff @(posedge clock) begin
		if (!nrst) begin
			hs_enable <= SPC_RST[SPC_IDX_HS][SPC_EN_BIT];
			hs_source_sel <= SPC_RST[SPC_IDX_HS][SPC_SRC_LSB +: 2];
			aux_enable <= SPC_RST[SPC_IDX_AUX][SPC_EN_BIT];
			aux_source_sel <= SPC_RST[SPC_IDX_AUX][SPC_SRC_LSB +: 2];
			in_term_enable <= SPC_RST[SPC_IDX_RX][SPC_RX_TERM_BIT];
			pulse_term_sel <= 16'h0000;
			eq_level_high <= 16'h0000;
			preemphasis_level <= 2'h0;
			out_term_enable <= 1'b0;
			out_current_high <= 1'b0;
		end else begin
			hs_enable <= next_hs_enable;
			hs_source_sel <= next_hs_source_sel;
			aux_enable <= next_aux_enable;
			aux_source_sel <= next_aux_source_sel;
			in_term_enable <= next_in_term_enable;
			pulse_term_sel <= next_pulse_term_sel;
			eq_level_high <= next_eq_level_high;
			preemphasis_level <= next_preemphasis_level;
			out_term_enable <= next_out_term_enable;
			out_current_high <= next_out_current_high;
		end
	end

	// ----------------------------------------------------------------
	// One-hot crosspoint selects
	// ----------------------------------------------------------------
	generate
		for (genvar k = 0; k < 4; k++) begin : g_onehot
			assign hs_source_onehot[k] =
				hs_enable && (hs_source_sel == 2'(k));
			assign aux_source_onehot[k] =
				aux_enable && (aux_source_sel == 2'(k));
		end
	endgenerate
endmodule

// ==== dv/spc_board_straps.sv ====
// Board tie-off model that straps the configuration pins
module spc_board_straps
(
	// Strap plan, bit order {ocl, oto, pe[1:0], eq, src[1:0], en}
	input wire logic [7:0] strap_plan,
	// Pins
	output logic hs_channel_enable_pin,
	output logic [1:0] source_select_pins,
	output logic equalization_level_pin,
	output logic [1:0] preemphasis_level_pins,
	output logic output_termination_pin,
	output logic output_current_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Each pin is tied hard to the supply or to ground
	assign {output_current_pin, output_termination_pin, preemphasis_level_pins,
		equalization_level_pin, source_select_pins,
		hs_channel_enable_pin} = strap_plan;
endmodule

// ==== dv/spc_decode_chk.sv ====
// Concurrent checks on the strap decoder ports
module spc_decode_chk
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Bus
	input wire logic [SPC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_bvalid,
	// Pins
	input wire logic hs_channel_enable_pin,
	input wire logic [1:0] source_select_pins,
	input wire logic equalization_level_pin,
	input wire logic [1:0] preemphasis_level_pins,
	input wire logic output_termination_pin,
	input wire logic output_current_pin,
	// Settings
	input wire logic hs_enable,
	input wire logic [1:0] hs_source_sel,
	input wire logic [3:0] hs_source_onehot,
	input wire logic aux_enable,
	input wire logic [1:0] aux_source_sel,
	input wire logic [3:0] aux_source_onehot,
	input wire logic in_term_enable,
	input wire logic [15:0] pulse_term_sel,
	input wire logic [15:0] eq_level_high,
	input wire logic [1:0] preemphasis_level,
	input wire logic out_term_enable,
	input wire logic out_current_high,
	input wire logic serial_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pins;
	logic ar_hit;
	logic ar_map;
	assign pins = {output_current_pin, output_termination_pin,
		preemphasis_level_pins, equalization_level_pin, source_select_pins,
		hs_channel_enable_pin};
	assign ar_hit = s_axi_arvalid && s_axi_arready;
	assign ar_map = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= SPC_OFS_STRAP;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence quiet;
		($stable(pins) && nrst && !serial_mode) [*4];
	endsequence
	a_hs_route: assert property (
		hs_source_onehot == (hs_enable ? 4'h1 << hs_source_sel : 4'h0))
		else $error("high-speed one-hot disagrees with select");
	a_aux_route: assert property (
		aux_source_onehot == (aux_enable ? 4'h1 << aux_source_sel : 4'h0))
		else $error("aux one-hot disagrees with select");
	a_pin_fixed: assert property (
		!serial_mode |-> in_term_enable && pulse_term_sel == 16'h0)
		else $error("fixed receiver settings broken in pin mode");
	a_follow_en: assert property (
		quiet |-> hs_enable == hs_channel_enable_pin)
		else $error("channel enable does not follow pin");
	a_follow_src: assert property (
		quiet |-> hs_source_sel == source_select_pins &&
		aux_source_sel == source_select_pins) else $error("source mismatch");
	a_follow_eq: assert property (
		quiet |-> eq_level_high == {16{equalization_level_pin}})
		else $error("equalization does not follow pin");
	a_follow_tx: assert property (
		quiet |-> {preemphasis_level, out_term_enable, out_current_high} ==
		{preemphasis_level_pins, output_termination_pin, output_current_pin})
		else $error("transmitter settings do not follow pins");
	a_serial_sticky: assert property (
		serial_mode |=> serial_mode) else $error("register mode dropped");
	a_rd_takeover: assert property (
		ar_hit && ar_map |=> serial_mode) else $error("read gave no takeover");
	a_unmapped_keep: assert property (
		ar_hit && !ar_map && !serial_mode |=> !serial_mode)
		else $error("unmapped read caused takeover");
	a_pins_ignored: assert property (
		serial_mode && $past(serial_mode) && !$past(s_axi_bvalid) |->
		$stable(hs_enable) && $stable(eq_level_high))
		else $error("settings moved in register mode without a write");
	c_rd_takeover: cover property (ar_hit && ar_map && !serial_mode);
	c_write: cover property (s_axi_bvalid && serial_mode);
	c_pin_move: cover property (!serial_mode && $changed(pins));
endmodule

bind spc_pin_config_decode spc_decode_chk u_spc_decode_chk (.clock, .nrst,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
	.hs_channel_enable_pin, .source_select_pins, .equalization_level_pin,
	.preemphasis_level_pins, .output_termination_pin, .output_current_pin,
	.hs_enable, .hs_source_sel, .hs_source_onehot, .aux_enable,
	.aux_source_sel, .aux_source_onehot, .in_term_enable, .pulse_term_sel,
	.eq_level_high, .preemphasis_level, .out_term_enable, .out_current_high,
	.serial_mode);

// ==== dv/spc_pin_config_decode_test.sv ====
// Self-checking bench of the strap decoder
module spc_pin_config_decode_test
	import spc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd32;
	logic [3:0] s_axi_wstrb, hs_source_onehot, aux_source_onehot;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, hs_source_sel, aux_source_sel;
	logic hs_channel_enable_pin, equalization_level_pin;
	logic output_termination_pin, output_current_pin;
	logic [1:0] source_select_pins, preemphasis_level_pins, preemphasis_level;
	logic hs_enable, aux_enable, in_term_enable, out_term_enable;
	logic out_current_high, serial_mode;
	logic [15:0] pulse_term_sel, eq_level_high;
	logic [7:0] plan, p;
	int miscompares, n_compared;
	// Rows: strap plan beside the expected high-speed one-hot
	logic [11:0] rows [5] = '{12'h491, 12'h932, 12'hED4, 12'h378, 12'h0E0};

	spc_board_straps u_spc_board_straps (.strap_plan(plan),
		.hs_channel_enable_pin, .source_select_pins, .equalization_level_pin,
		.preemphasis_level_pins, .output_termination_pin, .output_current_pin);
	spc_pin_config_decode u_spc_pin_config_decode (.clock, .nrst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.hs_channel_enable_pin, .source_select_pins, .equalization_level_pin,
		.preemphasis_level_pins, .output_termination_pin, .output_current_pin,
		.hs_enable, .hs_source_sel, .hs_source_onehot, .aux_enable,
		.aux_source_sel, .aux_source_onehot, .in_term_enable, .pulse_term_sel,
		.eq_level_high, .preemphasis_level, .out_term_enable,
		.out_current_high, .serial_mode);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic timeout();
		miscompares++;
		$display("CHECK FAILED at %0t: bus answer missing", $time);
		stop_test();
	endtask
	task automatic axi_write(input logic [5:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic aw, w, b;
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clock);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clock);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			if (b)
				break;
		end
		s_axi_bready <= 1'b0;
		if (n == 40)
			timeout();
	endtask
	task automatic axi_read(input logic [5:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, b;
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clock);
			ar = s_axi_arvalid && s_axi_arready;
			b = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clock);
			if (ar)
				s_axi_arvalid <= 1'b0;
			if (b)
				break;
		end
		s_axi_rready <= 1'b0;
		if (n == 40)
			timeout();
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		miscompares = 0;
		n_compared = 0;
		nrst = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_awaddr = 6'h00;
		s_axi_araddr = 6'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		plan = 8'h08; // Equalization strapped high by default
		repeat (8) @(posedge clock);
		check({s_axi_awready, serial_mode, aux_enable, in_term_enable,
			hs_enable}, 5'h16, "reset state");
		nrst <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			plan <= rows[i][11:4];
			repeat (4) @(posedge clock);
			@(negedge clock);
			p = rows[i][11:4];
			check({hs_enable, hs_source_onehot, aux_source_onehot},
				{p[0], rows[i][3:0], 4'h1 << p[2:1]}, "route");
			check(eq_level_high, {16{p[3]}}, "equalization");
			check({preemphasis_level, out_term_enable, out_current_high},
				{p[5:4], p[6], p[7]}, "transmitter");
			check({in_term_enable, pulse_term_sel, serial_mode},
				{1'b1, 16'h0, 1'b0}, "receiver fixed");
		end
		// Unmapped read, then strap read that hands over to registers
		axi_read(6'h28, rd32, resp);
		check(resp, SPC_RESP_DECERR, "unmapped read response");
		check(rd32, 32'h0, "unmapped read data");
		@(negedge clock);
		check(serial_mode, 1'b0, "unmapped kept pins");
		axi_read(SPC_OFS_STRAP, rd32, resp);
		check(rd32, 32'h0E, "strap readback");
		@(posedge clock);
		plan <= 8'h37;
		repeat (5) @(negedge clock);
		check({serial_mode, hs_enable, hs_source_sel, eq_level_high},
			{2'b10, 2'h3, 16'hFFFF}, "pins ignored");
		axi_write(SPC_OFS_RX, 8'h00, resp);
		axi_write(SPC_OFS_TX, 8'hFF, resp);
		axi_write(SPC_OFS_HS_MODES, 8'h42, resp);
		axi_write(SPC_OFS_EQ1, 8'hA5, resp);
		axi_write(SPC_OFS_PULSE1, 8'h3C, resp);
		repeat (2) @(negedge clock);
		check(resp, SPC_RESP_OKAY, "write response");
		check({in_term_enable, out_term_enable}, 2'b01, "terminations");
		check({hs_enable, hs_source_onehot}, 5'h14, "register route");
		check({eq_level_high, pulse_term_sel}, {16'hFFA5, 16'h003C},
			"register settings");
		axi_write(6'h30, 8'hFF, resp);
		check(resp, SPC_RESP_DECERR, "unmapped write");
		axi_read(SPC_OFS_TX, rd32, resp);
		check(rd32, 32'h0F, "transmitter readback");
		axi_read(SPC_OFS_STATUS, rd32, resp);
		check(rd32, 32'h01, "status readback");
		// Second reset gives control back to the pins
		@(posedge clock);
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(negedge clock);
		check({serial_mode, hs_source_onehot, preemphasis_level},
			{1'b0, 4'h8, 2'h3}, "pins govern again");
		stop_test();
	end
endmodule
